// *** bench/sel_far_end.sv ***
// far end of the link: a master that frames bytes for the block
// assumes the system clock paces an 80 ns link half period
`timescale 1ns/10ps
module sel_far_end (
  input wire clk, // system clock
  output logic sck, // link clock, still between frames
  output logic mosi, // data toward the block
  output logic ss_n, // select, active low
  output logic miso // return line, no slave selected
);
  localparam int HALF = 8;
  initial begin
    {sck, mosi, ss_n, miso} = 4'b0010;
  end
  // nobody drives this line, so it must not look like a held bit
  always @(negedge clk) miso <= ~miso;
  // n clock cycles are sent; fewer than eight aborts the frame
  task xfer(input logic [7:0] b, input logic ph, input int n,
      input logic desel);
    int i;
    ss_n = 1'b0;
    for (i = 0; i < n; i++) begin
      if (!ph) mosi = b[7 - i];
      repeat (HALF) @(negedge clk);
      if (ph) mosi = b[7 - i];
      sck = 1'b1;
      repeat (HALF) @(negedge clk);
      sck = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    if (desel) begin
      ss_n = 1'b1;
      mosi = ~mosi;
    end
    repeat (HALF) @(negedge clk);
  endtask
endmodule

// *** bench/sel_spi_sva.sv ***
// checker for the serial link error and request logic
// assumes it is bound to sel_spi_err and sees only its ports
`timescale 1ns/10ps
module sel_spi_sva (
  input wire clk, // clock
  input wire reset, // sync reset
  input wire ctrl_wr, // control write
  input wire data_rd, // data read
  input wire master_select, // mode
  input wire fault_detect_enable, // fault enable
  input wire error_irq_enable, // error gate
  input wire tx_irq_enable, // tx gate
  input wire rx_irq_enable, // rx gate
  input wire [7:0] rx_data, // rx register
  input wire link_enable, // link on
  input wire tx_empty_flag, // tx empty
  input wire rx_full_flag, // rx full
  input wire overflow_flag, // overflow
  input wire mode_fault_flag, // mode fault
  input wire tx_irq, // tx request
  input wire rx_err_irq, // rx/error request
  input wire serial_clock_pin_oe, // clock drive
  input wire mosi_oe, // mosi drive
  input wire miso_oe, // miso drive
  input wire ss_n_in // select pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_master_fault;
    $rose(mode_fault_flag) && master_select && $past(link_enable);
  endsequence
  sequence s_slave_fault;
    $rose(mode_fault_flag) && !master_select && !$past(ctrl_wr);
  endsequence
  chk_tx_req_gate: assert property (
    tx_irq == (tx_empty_flag && tx_irq_enable && link_enable))
    else $error("tx request wrong");
  chk_rx_req_gate: assert property (
    rx_err_irq == ((rx_full_flag && rx_irq_enable) ||
      (error_irq_enable && (overflow_flag || mode_fault_flag))))
    else $error("rx/error request wrong");
  chk_fault_enable: assert property (
    $rose(mode_fault_flag) |->
      $past(fault_detect_enable) || $past(fault_detect_enable, 2))
    else $error("fault set while disabled");
  chk_master_fault: assert property (
    s_master_fault |-> ##[0:1] (!link_enable && tx_empty_flag))
    else $error("master fault side effects missing");
  chk_slave_keeps: assert property (
    s_slave_fault |-> link_enable == $past(link_enable))
    else $error("slave fault changed link");
  chk_master_pins: assert property (
    link_enable && master_select |->
      serial_clock_pin_oe && mosi_oe && !miso_oe)
    else $error("master pin directions wrong");
  chk_slave_float: assert property (
    (!master_select && ss_n_in) [*3] |->
      !miso_oe && !serial_clock_pin_oe && !mosi_oe)
    else $error("deselected slave drives");
  chk_rx_clears: assert property (
    $fell(overflow_flag) || $fell(rx_full_flag) |-> $past(data_rd))
    else $error("rx flag cleared without data read");
  chk_fault_clear: assert property (
    $fell(mode_fault_flag) |-> $past(ctrl_wr))
    else $error("fault cleared without control write");
  chk_ovf_holds: assert property (
    overflow_flag && $past(overflow_flag) |->
      $stable(rx_data) && !$rose(rx_full_flag))
    else $error("byte accepted during overflow");
endmodule
bind sel_spi_err sel_spi_sva sel_spi_sva_i (.clk, .reset, .ctrl_wr,
  .data_rd, .master_select, .fault_detect_enable, .error_irq_enable,
  .tx_irq_enable, .rx_irq_enable, .rx_data, .link_enable, .tx_empty_flag,
  .rx_full_flag, .overflow_flag, .mode_fault_flag, .tx_irq, .rx_err_irq,
  .serial_clock_pin_oe, .mosi_oe, .miso_oe, .ss_n_in);

// *** bench/testbench.sv ***
// self-checking bench for the serial link error and request logic
// assumes the checker and the far end model are compiled before it
`timescale 1ns/10ps
module testbench;
  logic clk, reset, ctrl_wr, ctrl_wr_link_enable, master_select;
  logic clock_phase, clock_polarity, fault_detect_enable;
  logic error_irq_enable, tx_irq_enable, rx_irq_enable;
  logic status_rd, data_rd, tx_in_valid;
  logic [7:0] tx_in_data;
  wire [7:0] rx_data;
  wire tx_in_ready, link_enable, tx_empty_flag, rx_full_flag, tx_irq;
  wire overflow_flag, mode_fault_flag, rx_err_irq, miso_out, miso_oe;
  wire serial_clock_pin_out, serial_clock_pin_oe, mosi_out, mosi_oe;
  wire far_sck, far_mosi, far_ss_n, far_miso, ss_n_in;
  wire serial_clock_pin_in, mosi_in, miso_in;
  int err_total = 0;
  int n_compared = 0;
  // far end idles low; flip it so that its idle matches the polarity
  assign serial_clock_pin_in = serial_clock_pin_oe ?
    serial_clock_pin_out : (far_sck ^ clock_polarity);
  assign mosi_in = mosi_oe ? mosi_out : far_mosi;
  assign miso_in = miso_oe ? miso_out : far_miso;
  assign ss_n_in = far_ss_n;
  sel_spi_err sel_spi_err_i (.clk, .reset, .ctrl_wr, .ctrl_wr_link_enable,
    .master_select, .clock_phase, .clock_polarity, .fault_detect_enable,
    .error_irq_enable, .tx_irq_enable, .rx_irq_enable, .status_rd, .data_rd,
    .tx_in_valid, .tx_in_ready, .tx_in_data, .rx_data, .link_enable,
    .tx_empty_flag, .rx_full_flag, .overflow_flag, .mode_fault_flag, .tx_irq,
    .rx_err_irq, .serial_clock_pin_in, .serial_clock_pin_out,
    .serial_clock_pin_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in,
    .miso_out, .miso_oe, .ss_n_in);
  sel_far_end sel_far_end_i (.clk, .sck(far_sck), .mosi(far_mosi),
    .ss_n(far_ss_n), .miso(far_miso));
  always #5 clk = ~clk;
  task check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task end_sim;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // which: 0 status read, 1 data read, 2 control write of v
  task strobe(input int which, input logic v);
    @(negedge clk);
    ctrl_wr_link_enable = v;
    status_rd = (which == 0);
    data_rd = (which == 1);
    ctrl_wr = (which == 2);
    @(negedge clk);
    {status_rd, data_rd, ctrl_wr} = 3'b000;
    @(negedge clk);
  endtask
  // mode and format change only with the link off
  task setup(input logic ms, input logic ph);
    strobe(2, 1'b0);
    master_select = ms;
    clock_phase = ph;
    strobe(2, 1'b1);
  endtask
  task sc_slave_rx;
    setup(1'b0, 1'b1);
    rx_irq_enable = 1'b1;
    sel_far_end_i.xfer(8'ha5, 1'b1, 8, 1'b1);
    check(rx_full_flag === 1'b1 && rx_data === 8'ha5, "slave byte");
    check(mode_fault_flag === 1'b0, "fault after whole frame");
    strobe(2, 1'b0);
    check(rx_err_irq === 1'b1, "rx request with link off");
    strobe(0, 1'b0);
    strobe(1, 1'b0);
    check(rx_full_flag === 1'b0 && rx_err_irq === 1'b0, "rx clear");
    rx_irq_enable = 1'b0;
  endtask
  task sc_overflow;
    clock_polarity = 1'b1;
    setup(1'b0, 1'b0);
    error_irq_enable = 1'b1;
    sel_far_end_i.xfer(8'h3c, 1'b0, 8, 1'b1);
    sel_far_end_i.xfer(8'hc3, 1'b0, 6, 1'b1);
    check(overflow_flag === 1'b0, "overflow before bit 1");
    sel_far_end_i.xfer(8'hc3, 1'b0, 7, 1'b1);
    check(overflow_flag === 1'b1 && rx_err_irq === 1'b1, "overflow");
    sel_far_end_i.xfer(8'h5a, 1'b0, 8, 1'b1);
    check(rx_data === 8'h3c, "unread byte kept");
    strobe(1, 1'b0);
    check(overflow_flag === 1'b1, "data read alone");
    strobe(0, 1'b0);
    strobe(1, 1'b0);
    strobe(0, 1'b0);
    check(overflow_flag === 1'b0 && rx_full_flag === 1'b0, "ovf clr");
  endtask
  task sc_fault;
    error_irq_enable = 1'b0;
    sel_far_end_i.xfer(8'h00, 1'b0, 0, 1'b1);
    check(mode_fault_flag === 1'b0, "fault while disabled");
    fault_detect_enable = 1'b1;
    setup(1'b0, 1'b1);
    sel_far_end_i.xfer(8'h00, 1'b1, 0, 1'b1);
    check(mode_fault_flag === 1'b0, "phase 1 select only");
    setup(1'b0, 1'b0);
    sel_far_end_i.xfer(8'h00, 1'b0, 0, 1'b1);
    check(mode_fault_flag === 1'b1, "phase 0 select only");
    check(link_enable === 1'b1, "slave fault keeps link");
    error_irq_enable = 1'b1;
    fault_detect_enable = 1'b0;
    repeat (3) @(negedge clk);
    check(mode_fault_flag === 1'b1 && rx_err_irq === 1'b1, "kept");
    setup(1'b0, 1'b0);
    check(mode_fault_flag === 1'b1, "write without status");
    strobe(0, 1'b0);
    strobe(2, 1'b1);
    check(mode_fault_flag === 1'b0, "fault clear");
    fault_detect_enable = 1'b1;
  endtask
  task sc_master;
    int n;
    strobe(2, 1'b0);
    master_select = 1'b1;
    tx_irq_enable = 1'b1;
    tx_in_valid = 1'b1;
    for (n = 0; n < 12 && tx_in_ready === 1'b1; n++) begin
      tx_in_data = 8'h81 + n[7:0];
      @(negedge clk);
    end
    tx_in_valid = 1'b0;
    check(n == 8 && tx_empty_flag === 1'b1, "no drain while off");
    check(tx_irq === 1'b0, "tx request needs link");
    strobe(2, 1'b1);
    check(serial_clock_pin_oe === 1'b1 && miso_oe === 1'b0, "master");
    for (n = 0; n < 400 && tx_in_ready !== 1'b1; n++) @(negedge clk);
    check(tx_in_ready === 1'b1, "queue drains");
    if (tx_in_ready !== 1'b1) end_sim;
    @(negedge clk);
    check(mosi_out === 1'b1 && serial_clock_pin_out === 1'b1, "msb");
    sel_far_end_i.xfer(8'h00, 1'b0, 0, 1'b0);
    check(mode_fault_flag === 1'b1 && link_enable === 1'b0, "fault");
    check(tx_empty_flag === 1'b1 && tx_irq === 1'b0, "tx empty");
    sel_far_end_i.xfer(8'h00, 1'b1, 0, 1'b1);
    strobe(0, 1'b0);
    strobe(2, 1'b0);
    check(mode_fault_flag === 1'b0, "clr");
    check(serial_clock_pin_oe === 1'b0, "master inert while off");
  endtask
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {ctrl_wr, ctrl_wr_link_enable, master_select, clock_phase} = 4'h0;
    {clock_polarity, fault_detect_enable, error_irq_enable} = 3'b000;
    {tx_irq_enable, rx_irq_enable, status_rd, data_rd} = 4'h0;
    tx_in_valid = 1'b0;
    tx_in_data = 8'h00;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    sc_slave_rx;
    sc_overflow;
    sc_fault;
    sc_master;
    end_sim;
  end
endmodule

// *** include/sel_spi_map.vh ***
// constants for the serial link error and request logic
// assumes a 100 MHz system clock; included by bare name
`ifndef SEL_SPI_MAP_VH
`define SEL_SPI_MAP_VH

// timing
`define SEL_CLK_NS 10
`define SEL_SCK_HALF_NS 80
`define SEL_SCK_HALF_CYC (`SEL_SCK_HALF_NS / `SEL_CLK_NS)
`define SEL_DIV_W 4

// frame layout
`define SEL_BITS 8
`define SEL_MSB 7
`define SEL_CNT_W 4
`define SEL_CNT_BIT1 4'h6
`define SEL_CNT_LAST_P1 4'h7
`define SEL_CNT_LAST_P0 4'h8

// pin bit positions in the synchroniser vector
`define SEL_PIN_SCK 0
`define SEL_PIN_MOSI 1
`define SEL_PIN_MISO 2
`define SEL_PIN_SSN 3
`define SEL_PIN_N 4

// reset values
`define SEL_RST_BYTE 8'h00
`define SEL_RST_CNT 4'h0
`define SEL_RST_DIV 4'h0
`define SEL_RST_PINS 4'h8

// transmit queue
`define SEL_FIFO_W 8
`define SEL_FIFO_D 8
`define SEL_FIFO_AW 3

`endif

// *** src/sel_spi_err.v ***
// serial link core with error detection and cpu request generation,
// plus the transmit queue that feeds its transmit data register.
// assumes all control/status strobes come from logic on clk, and the
// link pins come from outside and are synchronised here.
`timescale 1ns/10ps
`include "sel_spi_map.vh"

module sel_fifo #(
  parameter W = `SEL_FIFO_W,
  parameter D = `SEL_FIFO_D,
  parameter AW = `SEL_FIFO_AW
) (
  input wire clk, // system clock
  input wire reset, // synchronous, active high
  input wire in_valid, // writer offers a word
  output wire in_ready, // queue has room
  input wire [W-1:0] in_data, // word offered
  output wire out_valid, // queue holds a word
  input wire out_ready, // reader takes the word
  output wire [W-1:0] out_data // oldest word
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;
  localparam [AW:0] DEPTH = D;

  assign in_ready = (count_reg != DEPTH);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// How it works
// R1: overflow sets if receive register is unread at the bit-1 capture
// R2: while overflow is set, received bytes are dropped and receive-full stays
// R3: overflow clears by status read, then data read
// R4: one error enable gates overflow and mode fault onto the receive request
// R5: master drives clock and mosi, slave drives miso; reversed when slave
// R6: mode fault sets only with fault detect enabled; disabling keeps the flag
// R7: master fault: link off, tx empty set, counter cleared, pins freed
// R8: slave fault when select rises during a transfer
// R9: phase 0 starts on select fall; phase 1 on first clock edge
// R10: phase 0 select then deselect faults even without clock edges
// R11: mode fault leaves master select unchanged; it is inert while disabled
// R12: slave fault neither disables the link nor resets other logic
// R13: deselected slave floats miso and ignores all clock edges
// R14: mode fault clears by status read seeing it, then control write
// R15: transmit request needs tx empty, its enable and link enable
// R16: receive request needs receive-full and its enable, regardless of link
// R17: receive-full clears by status read with it set, then data read
// R18: only a transmit data register load clears tx empty
// R19: receive-full sets when a byte moves into the receive register
// R20: tx empty sets when the transmit register moves into the shifter
// R21: polling software rereads status after data read to catch overflow
// R22: link disabled sets tx empty, aborts, clears shifter and frees pins
// R23: all flags and requests run on clk; pins are synchronised first
module sel_spi_err (
  input wire clk, // system clock, 100 MHz
  input wire reset, // synchronous, active high
  input wire ctrl_wr, // pulse: control register write
  input wire ctrl_wr_link_enable, // link enable value written
  input wire master_select, // 1 master, 0 slave
  input wire clock_phase, // transmission format
  input wire clock_polarity, // idle level of the serial clock
  input wire fault_detect_enable, // allows mode fault
  input wire error_irq_enable, // gates overflow and mode fault
  input wire tx_irq_enable, // gates tx empty
  input wire rx_irq_enable, // gates receive-full
  input wire status_rd, // pulse: status register read
  input wire data_rd, // pulse: receive data register read
  input wire tx_in_valid, // transmit byte offered
  output wire tx_in_ready, // transmit queue has room
  input wire [7:0] tx_in_data, // transmit byte
  output wire [7:0] rx_data, // receive data register
  output wire link_enable, // link enable state
  output wire tx_empty_flag, // transmit register empty
  output wire rx_full_flag, // receive register full
  output wire overflow_flag, // receive overflow
  output wire mode_fault_flag, // select pin inconsistent with mode
  output wire tx_irq, // transmitter request
  output wire rx_err_irq, // receiver/error request
  input wire serial_clock_pin_in, // clock pin level
  output wire serial_clock_pin_out, // clock driven as master
  output wire serial_clock_pin_oe, // clock pin driven
  input wire mosi_in, // master-out pin level
  output wire mosi_out, // master-out data
  output wire mosi_oe, // master-out driven
  input wire miso_in, // master-in pin level
  output wire miso_out, // slave-out data
  output wire miso_oe, // slave-out driven
  input wire ss_n_in // slave select pin, active low
);
  reg [`SEL_PIN_N-1:0] pin_meta_reg;
  reg [`SEL_PIN_N-1:0] pin_sync_reg;
  reg sck_prev_reg;
  reg ss_prev_reg;
  reg link_en_reg;
  reg tx_empty_reg;
  reg rx_full_reg;
  reg ovf_reg;
  reg mode_fault_flag_reg;
  reg rx_arm_reg;
  reg ovf_arm_reg;
  reg mode_fault_flag_arm_reg;
  reg [7:0] tdr_reg;
  reg [7:0] rdr_reg;
  reg [7:0] tx_sh_reg;
  reg [7:0] rx_sh_reg;
  reg [`SEL_CNT_W-1:0] bit_cnt_reg;
  reg active_reg;
  reg [`SEL_DIV_W-1:0] div_cnt_reg;
  reg sck_out_reg;

  wire [`SEL_PIN_N-1:0] pins_in;
  wire [`SEL_PIN_N-1:0] pins_rst;
  wire ss_rise;
  wire sck_s;
  wire ss_s;
  wire din;
  wire is_master;
  wire slave_mode;
  wire slave_sel;
  wire s_lead;
  wire s_trail;
  wire ss_fall;
  wire m_tick;
  wire m_lead;
  wire m_trail;
  wire lead_ev;
  wire trail_ev;
  wire capture_ev;
  wire shift_ev;
  wire done;
  wire m_start;
  wire s_start;
  wire start;
  wire master_fault;
  wire slave_fault;
  wire fault_cond;
  wire ovf_set;
  wire rx_set;
  wire mode_fault_flag_set;
  wire tdr_load;
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire [7:0] rx_word;

  // transmit queue: drains only while the transmit register is empty
  sel_fifo #(
    .W(`SEL_FIFO_W),
    .D(`SEL_FIFO_D),
    .AW(`SEL_FIFO_AW)
  ) u_txq (
    .clk(clk),
    .reset(reset),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .in_data(tx_in_data),
    .out_valid(fifo_valid),
    .out_ready(tdr_load),
    .out_data(fifo_data)
  );

  assign pins_in = {ss_n_in, miso_in, mosi_in, serial_clock_pin_in};
  assign pins_rst = `SEL_RST_PINS;

  // two-stage synchroniser per pin; only stage two is read
  genvar gi;
  generate
    for (gi = 0; gi < `SEL_PIN_N; gi = gi + 1) begin : g_sync
      always @(posedge clk) begin
        if (reset) begin
          pin_meta_reg[gi] <= pins_rst[gi]; // [R23]
          pin_sync_reg[gi] <= pins_rst[gi];
        end else begin
          pin_meta_reg[gi] <= pins_in[gi]; // [R23]
          pin_sync_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  assign sck_s = pin_sync_reg[`SEL_PIN_SCK];
  assign ss_s = pin_sync_reg[`SEL_PIN_SSN];

  // master select only matters while the link is on
  assign is_master = link_en_reg && master_select; // [R11]
  assign slave_mode = link_en_reg && !master_select;
  assign slave_sel = slave_mode && !ss_s; // [R13]
  assign din = is_master ? pin_sync_reg[`SEL_PIN_MISO] :
               pin_sync_reg[`SEL_PIN_MOSI];

  assign s_lead = (sck_s != clock_polarity) &&
                  (sck_prev_reg == clock_polarity);
  assign s_trail = (sck_s == clock_polarity) &&
                   (sck_prev_reg != clock_polarity);
  assign ss_fall = ss_prev_reg && !ss_s;
  assign ss_rise = !ss_prev_reg && ss_s;

  assign m_tick = is_master && active_reg &&
                  (div_cnt_reg == `SEL_SCK_HALF_CYC - 1);
  assign m_lead = m_tick && (sck_out_reg == clock_polarity);
  assign m_trail = m_tick && (sck_out_reg != clock_polarity);

  // a deselected slave sees no clock edges at all
  assign lead_ev = is_master ? m_lead :
                   (slave_sel && active_reg && s_lead); // [R13]
  assign trail_ev = is_master ? m_trail :
                    (slave_sel && active_reg && s_trail); // [R13]
  assign capture_ev = clock_phase ? trail_ev : lead_ev;
  assign shift_ev = clock_phase ? lead_ev : trail_ev;

  // phase 0 ends on the return to idle after bit 8, phase 1 with bit 8
  assign done = trail_ev &&
    ((clock_phase && bit_cnt_reg == `SEL_CNT_LAST_P1) ||
     (!clock_phase && bit_cnt_reg == `SEL_CNT_LAST_P0)); // [R9]

  assign m_start = is_master && !active_reg && !tx_empty_reg &&
                   !master_fault;
  assign s_start = (!clock_phase && slave_mode && ss_fall) ||
                   (clock_phase && slave_sel && !active_reg &&
                    s_lead); // [R9]
  assign start = m_start || s_start;

  assign master_fault = is_master && fault_detect_enable && !ss_s; // [R7]
  // the rising edge, not the level: enabling detection later must not
  // fault on a deselect that already happened
  assign slave_fault = slave_mode && fault_detect_enable && ss_rise &&
                       active_reg; // [R8] [R10]
  assign fault_cond = master_fault || slave_fault;
  assign mode_fault_flag_set = fault_cond; // [R6]

  assign ovf_set = capture_ev && bit_cnt_reg == `SEL_CNT_BIT1 &&
                   rx_full_reg; // [R1]
  assign rx_word = clock_phase ? {rx_sh_reg[6:0], din} : rx_sh_reg;
  assign rx_set = done && !ovf_reg && !ovf_set; // [R2] [R19]

  assign tdr_load = fifo_valid && tx_empty_reg && link_en_reg &&
                    !master_fault;

  always @(posedge clk) begin
    if (reset) begin
      sck_prev_reg <= 1'b0;
      ss_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_s;
      ss_prev_reg <= ss_s;
    end
  end

  // link enable: a master fault overrides a simultaneous write
  always @(posedge clk) begin
    if (reset) begin
      link_en_reg <= 1'b0;
    end else if (master_fault) begin
      link_en_reg <= 1'b0; // [R7]
    end else if (ctrl_wr) begin
      link_en_reg <= ctrl_wr_link_enable; // [R12]
    end
  end

  // transfer sequencing, shifters and master clock
  always @(posedge clk) begin
    if (reset) begin
      active_reg <= 1'b0;
      bit_cnt_reg <= `SEL_RST_CNT;
      tx_sh_reg <= `SEL_RST_BYTE;
      rx_sh_reg <= `SEL_RST_BYTE;
      div_cnt_reg <= `SEL_RST_DIV;
      sck_out_reg <= 1'b0;
    end else if (!link_en_reg || master_fault) begin
      active_reg <= 1'b0; // [R22] [R7]
      bit_cnt_reg <= `SEL_RST_CNT;
      tx_sh_reg <= `SEL_RST_BYTE;
      rx_sh_reg <= `SEL_RST_BYTE;
      div_cnt_reg <= `SEL_RST_DIV;
      sck_out_reg <= clock_polarity;
    end else if (start) begin
      active_reg <= 1'b1;
      bit_cnt_reg <= `SEL_RST_CNT;
      div_cnt_reg <= `SEL_RST_DIV;
      sck_out_reg <= clock_polarity;
      // with nothing queued the slave resends the old shifter contents
      if (!tx_empty_reg) begin
        tx_sh_reg <= tdr_reg;
      end
    end else if (active_reg) begin
      if (is_master) begin
        if (m_tick) begin
          div_cnt_reg <= `SEL_RST_DIV;
          sck_out_reg <= !sck_out_reg;
        end else begin
          div_cnt_reg <= div_cnt_reg + 1'b1;
        end
      end
      if (capture_ev) begin
        rx_sh_reg <= {rx_sh_reg[6:0], din};
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
      if (shift_ev && bit_cnt_reg != `SEL_RST_CNT &&
          bit_cnt_reg != `SEL_CNT_LAST_P0) begin
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
      end
      if (done) begin
        active_reg <= 1'b0;
        bit_cnt_reg <= `SEL_RST_CNT;
      end
    end else begin
      sck_out_reg <= clock_polarity;
    end
  end

  // transmit data register and its empty flag; sets win over the load
  always @(posedge clk) begin
    if (reset) begin
      tdr_reg <= `SEL_RST_BYTE;
      tx_empty_reg <= 1'b1;
    end else if (!link_en_reg || master_fault) begin
      tx_empty_reg <= 1'b1; // [R22] [R7]
    end else if (start && !tx_empty_reg) begin
      tx_empty_reg <= 1'b1; // [R20]
    end else if (tdr_load) begin
      tdr_reg <= fifo_data;
      tx_empty_reg <= 1'b0; // [R18]
    end
  end

  // receive data register and receive-full flag
  always @(posedge clk) begin
    if (reset) begin
      rdr_reg <= `SEL_RST_BYTE;
      rx_full_reg <= 1'b0;
      rx_arm_reg <= 1'b0;
    end else begin
      if (rx_set) begin
        rdr_reg <= rx_word; // [R19]
        rx_full_reg <= 1'b1;
      end else if (data_rd && rx_arm_reg) begin
        rx_full_reg <= 1'b0; // [R17]
      end
      if (status_rd) begin
        rx_arm_reg <= rx_full_reg; // [R17]
      end else if (data_rd) begin
        rx_arm_reg <= 1'b0;
      end
    end
  end

  // overflow flag: survives link disable, only reset or the read pair
  always @(posedge clk) begin
    if (reset) begin
      ovf_reg <= 1'b0;
      ovf_arm_reg <= 1'b0;
    end else begin
      if (ovf_set) begin
        ovf_reg <= 1'b1; // [R1]
      end else if (data_rd && ovf_arm_reg) begin
        ovf_reg <= 1'b0; // [R3]
      end
      if (status_rd) begin
        ovf_arm_reg <= ovf_reg; // [R3]
      end else if (data_rd) begin
        ovf_arm_reg <= 1'b0;
      end
    end
  end

  // mode fault flag: any fault during the clear sequence cancels it
  always @(posedge clk) begin
    if (reset) begin
      mode_fault_flag_reg <= 1'b0;
      mode_fault_flag_arm_reg <= 1'b0;
    end else begin
      if (mode_fault_flag_set) begin
        mode_fault_flag_reg <= 1'b1; // [R6] [R7] [R8]
      end else if (ctrl_wr && mode_fault_flag_arm_reg) begin
        mode_fault_flag_reg <= 1'b0; // [R14]
      end
      if (fault_cond) begin
        mode_fault_flag_arm_reg <= 1'b0; // [R14]
      end else if (status_rd) begin
        mode_fault_flag_arm_reg <= mode_fault_flag_reg;
      end else if (ctrl_wr) begin
        mode_fault_flag_arm_reg <= 1'b0;
      end
    end
  end

  assign rx_data = rdr_reg;
  assign link_enable = link_en_reg;
  assign tx_empty_flag = tx_empty_reg;
  assign rx_full_flag = rx_full_reg;
  assign overflow_flag = ovf_reg;
  assign mode_fault_flag = mode_fault_flag_reg;

  assign tx_irq = tx_empty_reg && tx_irq_enable && link_en_reg; // [R15]
  assign rx_err_irq = (rx_full_reg && rx_irq_enable) || // [R16]
    (error_irq_enable && (ovf_reg || mode_fault_flag_reg)); // [R4]

  // pin directions; port logic owns the pins while the link is off
  assign serial_clock_pin_out = sck_out_reg;
  assign serial_clock_pin_oe = is_master; // [R5] [R22]
  assign mosi_out = tx_sh_reg[`SEL_MSB];
  assign mosi_oe = is_master; // [R5]
  assign miso_out = tx_sh_reg[`SEL_MSB];
  assign miso_oe = slave_sel; // [R5] [R13]
endmodule
